// File: hw/sph_handshake.sv
// Parameter, configuration and diagnosis buffer handshake with APB access.
// Assumes the fieldbus engine runs on pclk and sends one telegram event
// per cycle; buffer memories live outside and use the ids given here.

// How it works
// - Long parameter telegram swaps buffer, irq raised
// - Application parameters start at byte 8/10
// - Parameter irq cleared only by command
// - Parameter reject sets diag, back to wait
// - Parameter command read returns 2-bit code
// - Second parameter telegram gives conflict code
// - Configuration telegram swaps buffer, irq raised
// - Configuration irq cleared only by command
// - Configuration reject updates diag, back wait
// - Accept enters exchange when counters zero
// - Second configuration telegram gives conflict code
// - Configuration command read returns 2-bit code
// - Two diagnosis buffers, one device-owned
// - New-diagnosis command swaps, irq confirms
// - Swap sets flag, flag means priority
// - Fetch clears flag unless static diagnosis
// - Diagnosis flag visible in status register
// - New-diagnosis read returns host buffer code
module sph_handshake (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire sph_pkg::sph_fb_evt_t fb_evt,
	output sph_pkg::sph_fb_ctl_t fb_ctl
);

	sph_pkg::sph_state_t state_ff, nxt_state;
	logic ack_ff;
	logic [31:0] prdata_ff, nxt_prdata;
	logic slverr_ff;
	logic [1:0] prm_cnt_ff, nxt_prm_cnt;
	logic [1:0] cfg_cnt_ff, nxt_cfg_cnt;
	logic new_prm_ff, new_cfg_ff;
	logic [7:0] prm_len_ff, cfg_len_ff;
	logic [1:0] aux_buf_ff, prm_buf_ff, cfg_buf_ff;
	logic ext_en_ff;
	logic dev_buf_ff;
	logic [1:0] host_buf_ff, nxt_host_buf;
	logic pend_ff, nxt_pend;
	logic diag_flag_ff;
	logic diag_chg_ff, exch_ff, prm_rej_ff, cfg_rej_ff;

	// Access phase decode; the action fires on the first access cycle
	wire [5:0] word = paddr[7:2];
	wire acc = psel & penable & ~ack_ff;
	wire rd = acc & ~pwrite;
	wire wr = acc & pwrite;
	wire hit_status = word == sph_pkg::IDX_STATUS;
	wire hit_ctrl = word == sph_pkg::IDX_CTRL;
	wire hit_len_prm = word == sph_pkg::IDX_LEN_PRM;
	wire hit_len_cfg = word == sph_pkg::IDX_LEN_CFG;
	wire hit_buf_map = word == sph_pkg::IDX_BUF_MAP;
	wire hit_diag_sm = word == sph_pkg::IDX_DIAG_SM;
	wire hit_new_diag = word == sph_pkg::IDX_NEW_DIAG;
	wire hit_prm_ok = word == sph_pkg::IDX_PRM_OK;
	wire hit_prm_nok = word == sph_pkg::IDX_PRM_NOK;
	wire hit_cfg_ok = word == sph_pkg::IDX_CFG_OK;
	wire hit_cfg_nok = word == sph_pkg::IDX_CFG_NOK;
	wire hit_cmd = hit_new_diag | hit_prm_ok | hit_prm_nok | hit_cfg_ok
		| hit_cfg_nok;
	wire hit_any = hit_cmd | hit_status | hit_ctrl | hit_len_prm
		| hit_len_cfg | hit_buf_map | hit_diag_sm;
	wire wr_ctrl = wr & hit_ctrl;

	// read-only triggers
	// Writes to command cells fall through every decode below
	wire cmd_prm_ok = rd & hit_prm_ok;
	wire cmd_prm_nok = rd & hit_prm_nok;
	wire cmd_cfg_ok = rd & hit_cfg_ok;
	wire cmd_cfg_nok = rd & hit_cfg_nok;
	wire cmd_diag = rd & hit_new_diag;

	// conflict on second telegram
	// A telegram landing in the same cycle as the read counts as pending
	wire prm_cmd = cmd_prm_ok | cmd_prm_nok;
	wire prm_allowed = prm_cnt_ff != 2'h0;
	wire prm_conflict = (prm_cnt_ff > 2'h1) | fb_evt.prm_valid;
	wire prm_done = prm_cmd & prm_allowed;
	wire prm_fin = prm_done & ~prm_conflict;
	wire [1:0] prm_code = !prm_allowed ? sph_pkg::RSP_NOT_ALLOWED
		: prm_conflict ? sph_pkg::RSP_CONFLICT : sph_pkg::RSP_FINISHED;

	// Both telegrams share the aux buffer; parameters win a collision
	wire cfg_take = fb_evt.cfg_valid & ~fb_evt.prm_valid;

	wire cfg_cmd = cmd_cfg_ok | cmd_cfg_nok;
	wire cfg_allowed = cfg_cnt_ff != 2'h0;
	wire cfg_conflict = (cfg_cnt_ff > 2'h1) | cfg_take;
	wire cfg_done = cfg_cmd & cfg_allowed;
	wire cfg_fin = cfg_done & ~cfg_conflict;
	wire [1:0] cfg_code = !cfg_allowed ? sph_pkg::RSP_NOT_ALLOWED
		: cfg_conflict ? sph_pkg::RSP_CONFLICT : sph_pkg::RSP_FINISHED;

	// swap only while the host holds a buffer
	wire diag_swap = cmd_diag & (host_buf_ff != sph_pkg::DG_NO_BUF);
	wire host_is_buf2 = host_buf_ff == sph_pkg::DG_BUF2;

	wire [7:0] prm_start = ext_en_ff ? sph_pkg::PRM_START_EXT
		: sph_pkg::PRM_START_STD;

	wire cnts_clear = (nxt_prm_cnt == 2'h0) & (nxt_cfg_cnt == 2'h0);

	// Trigger counters; a conflict ack leaves one telegram pending
	always_comb begin
		nxt_prm_cnt = prm_cnt_ff;
		if (prm_done) begin
			nxt_prm_cnt = (prm_cnt_ff > 2'h1) ? 2'h1 : 2'h0;
			if (fb_evt.prm_valid) begin
				nxt_prm_cnt = nxt_prm_cnt + 2'h1;
			end
		end else if (fb_evt.prm_valid && prm_cnt_ff != 2'h3) begin
			nxt_prm_cnt = prm_cnt_ff + 2'h1;
		end
		nxt_cfg_cnt = cfg_cnt_ff;
		if (cfg_done) begin
			nxt_cfg_cnt = (cfg_cnt_ff > 2'h1) ? 2'h1 : 2'h0;
			if (cfg_take) begin
				nxt_cfg_cnt = nxt_cfg_cnt + 2'h1;
			end
		end else if (cfg_take && cfg_cnt_ff != 2'h3) begin
			nxt_cfg_cnt = cfg_cnt_ff + 2'h1;
		end
	end

	// Slave state machine driven by host acknowledgements
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			sph_pkg::SPH_WAIT_PRM: begin
				if (prm_fin && cmd_prm_ok) begin
					nxt_state = sph_pkg::SPH_WAIT_CFG;
				end
			end
			sph_pkg::SPH_WAIT_CFG, sph_pkg::SPH_DATA_EXCHANGE_STATE: begin
				if (prm_done && cmd_prm_nok) begin
					nxt_state = sph_pkg::SPH_WAIT_PRM;
				end else if (cfg_done && cmd_cfg_nok) begin
					nxt_state = sph_pkg::SPH_WAIT_PRM;
				end else if (cfg_fin && cmd_cfg_ok && cnts_clear) begin
					nxt_state = sph_pkg::SPH_DATA_EXCHANGE_STATE;
				end
			end
			default: nxt_state = sph_pkg::SPH_WAIT_PRM;
		endcase
	end

	// Diagnosis ownership after a swap or the end of a send
	always_comb begin
		nxt_host_buf = host_buf_ff;
		nxt_pend = pend_ff;
		if (diag_swap) begin
			// Old device buffer stays with the device while it is sent
			nxt_pend = fb_evt.diag_sending;
			nxt_host_buf = fb_evt.diag_sending ? sph_pkg::DG_NO_BUF
				: (dev_buf_ff ? sph_pkg::DG_BUF2 : sph_pkg::DG_BUF1);
		end else if (pend_ff && !fb_evt.diag_sending) begin
			nxt_pend = 1'b0;
			nxt_host_buf = dev_buf_ff ? sph_pkg::DG_BUF1 : sph_pkg::DG_BUF2;
		end
	end

	// Read data mux; command cells show the code of this very access
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		if (hit_status) begin
			nxt_prdata[2:0] = state_ff;
			nxt_prdata[sph_pkg::ST_FLAG_BIT] = diag_flag_ff;
			nxt_prdata[sph_pkg::ST_PRM_IRQ_BIT] = new_prm_ff;
			nxt_prdata[sph_pkg::ST_CFG_IRQ_BIT] = new_cfg_ff;
			nxt_prdata[sph_pkg::ST_START_LSB +: 8] = prm_start;
		end else if (hit_ctrl) begin
			nxt_prdata[sph_pkg::CTRL_EXT_BIT] = ext_en_ff;
		end else if (hit_len_prm) begin
			nxt_prdata[7:0] = prm_len_ff;
		end else if (hit_len_cfg) begin
			nxt_prdata[7:0] = cfg_len_ff;
		end else if (hit_buf_map) begin
			nxt_prdata[5:0] = {cfg_buf_ff, prm_buf_ff, aux_buf_ff};
		end else if (hit_diag_sm) begin
			nxt_prdata[1:0] = diag_own(1'b0);
			nxt_prdata[3:2] = diag_own(1'b1);
		end else if (hit_new_diag) begin
			nxt_prdata[1:0] = nxt_host_buf;
		end else if (hit_prm_ok || hit_prm_nok) begin
			nxt_prdata[1:0] = prm_code;
		end else if (hit_cfg_ok || hit_cfg_nok) begin
			nxt_prdata[1:0] = cfg_code;
		end
	end

	// Ownership code of diagnosis buffer b (0 = one, 1 = two)
	function automatic logic [1:0] diag_own(input logic b);
		logic [1:0] code;
		code = sph_pkg::OWN_NIL;
		if (b == dev_buf_ff) begin
			code = fb_evt.diag_sending ? sph_pkg::OWN_SEND : sph_pkg::OWN_DEV;
		end else if (pend_ff) begin
			code = sph_pkg::OWN_SEND;
		end else if (host_buf_ff == (b ? sph_pkg::DG_BUF2 : sph_pkg::DG_BUF1))
		begin
			code = sph_pkg::OWN_USER;
		end
		return code;
	endfunction : diag_own

	// APB answer: one wait state, then pready with registered data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			slverr_ff <= 1'b0;
		end else begin
			ack_ff <= acc;
			if (acc) begin
				prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
				slverr_ff <= ~hit_any;     // Unmapped address
			end
		end
	end

	assign pready = psel & penable & ack_ff;
	assign pslverr = pready & slverr_ff;
	assign prdata = prdata_ff;

	// Host control bits; pwdata upper bits are ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_en_ff <= 1'b0;
		end else if (wr_ctrl) begin
			ext_en_ff <= pwdata[sph_pkg::CTRL_EXT_BIT];
		end
	end

	// State, counters and parameter/config buffer rotation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= sph_pkg::SPH_WAIT_PRM;
			prm_cnt_ff <= 2'h0;
			cfg_cnt_ff <= 2'h0;
			prm_len_ff <= 8'h00;
			cfg_len_ff <= 8'h00;
			aux_buf_ff <= sph_pkg::BUF_AUX_RST;
			prm_buf_ff <= sph_pkg::BUF_PRM_RST;
			cfg_buf_ff <= sph_pkg::BUF_CFG_RST;
		end else begin
			state_ff <= nxt_state;
			prm_cnt_ff <= nxt_prm_cnt;
			cfg_cnt_ff <= nxt_cfg_cnt;
			if (fb_evt.prm_valid) begin
				prm_buf_ff <= aux_buf_ff;
				aux_buf_ff <= prm_buf_ff;
				prm_len_ff <= fb_evt.prm_len;
			end else if (cfg_take) begin
				cfg_buf_ff <= aux_buf_ff;
				aux_buf_ff <= cfg_buf_ff;
				cfg_len_ff <= fb_evt.cfg_len;
			end
		end
	end

	// Interrupt levels: arrival sets, a finished ack clears, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			new_prm_ff <= 1'b0;
			new_cfg_ff <= 1'b0;
		end else begin
			if (fb_evt.prm_valid) begin
				new_prm_ff <= 1'b1;
			end else if (prm_fin) begin
				new_prm_ff <= 1'b0;
			end
			if (cfg_take) begin
				new_cfg_ff <= 1'b1;
			end else if (cfg_fin) begin
				new_cfg_ff <= 1'b0;
			end
		end
	end

	// Event pulses toward the engine and the interrupt controller
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exch_ff <= 1'b0;
			prm_rej_ff <= 1'b0;
			cfg_rej_ff <= 1'b0;
			diag_chg_ff <= 1'b0;
		end else begin
			exch_ff <= (nxt_state == sph_pkg::SPH_DATA_EXCHANGE_STATE)
				!= (state_ff == sph_pkg::SPH_DATA_EXCHANGE_STATE);
			prm_rej_ff <= prm_done & cmd_prm_nok;
			cfg_rej_ff <= cfg_done & cmd_cfg_nok;
			diag_chg_ff <= diag_swap;
		end
	end

	// Diagnosis buffers and the flag that asks for priority answers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_buf_ff <= 1'b0;
			host_buf_ff <= sph_pkg::DG_BUF2;
			pend_ff <= 1'b0;
			diag_flag_ff <= 1'b0;
		end else begin
			host_buf_ff <= nxt_host_buf;
			pend_ff <= nxt_pend;
			if (diag_swap) begin
				dev_buf_ff <= host_is_buf2;
			end
			if (diag_swap) begin
				diag_flag_ff <= 1'b1;
			end else if (fb_evt.diag_fetched && !fb_evt.stat_diag) begin
				diag_flag_ff <= 1'b0;
			end
		end
	end

	assign fb_ctl.hi_prio = diag_flag_ff;
	assign fb_ctl.state = state_ff;
	assign fb_ctl.aux_buf = aux_buf_ff;
	assign fb_ctl.prm_buf = prm_buf_ff;
	assign fb_ctl.cfg_buf = cfg_buf_ff;
	assign fb_ctl.diag_dev_buf = dev_buf_ff;
	assign fb_ctl.prm_start = prm_start;
	assign fb_ctl.new_prm_irq = new_prm_ff;
	assign fb_ctl.new_cfg_irq = new_cfg_ff;
	assign fb_ctl.diag_chg_irq = diag_chg_ff;
	assign fb_ctl.exch_irq = exch_ff;
	assign fb_ctl.prm_rej_diag = prm_rej_ff;
	assign fb_ctl.cfg_rej_diag = cfg_rej_ff;

endmodule : sph_handshake

// File: include/sph_pkg.sv
// Package for the parameter/configuration/diagnosis handshake block.
// Assumes a 32-bit APB slave port and a same-clock fieldbus engine.
package sph_pkg;

	// Register word indices; byte address is four times the index
	localparam logic [5:0] IDX_STATUS = 6'h04;
	localparam logic [5:0] IDX_CTRL = 6'h05;
	localparam logic [5:0] IDX_LEN_PRM = 6'h06;
	localparam logic [5:0] IDX_LEN_CFG = 6'h07;
	localparam logic [5:0] IDX_BUF_MAP = 6'h08;
	localparam logic [5:0] IDX_DIAG_SM = 6'h0C;
	localparam logic [5:0] IDX_NEW_DIAG = 6'h0D;
	localparam logic [5:0] IDX_PRM_OK = 6'h0E;
	localparam logic [5:0] IDX_PRM_NOK = 6'h0F;
	localparam logic [5:0] IDX_CFG_OK = 6'h10;
	localparam logic [5:0] IDX_CFG_NOK = 6'h11;

	// Command cell answers in bits 1-0
	localparam logic [1:0] RSP_FINISHED = 2'h0;
	localparam logic [1:0] RSP_CONFLICT = 2'h1;
	localparam logic [1:0] RSP_NOT_ALLOWED = 2'h3;

	// New-diagnosis answers
	localparam logic [1:0] DG_NO_BUF = 2'h0;
	localparam logic [1:0] DG_BUF1 = 2'h1;
	localparam logic [1:0] DG_BUF2 = 2'h2;

	// Diagnosis buffer ownership codes
	localparam logic [1:0] OWN_NIL = 2'h0;
	localparam logic [1:0] OWN_USER = 2'h1;
	localparam logic [1:0] OWN_DEV = 2'h2;
	localparam logic [1:0] OWN_SEND = 2'h3;

	// First application byte in the parameter buffer
	localparam logic [7:0] PRM_START_STD = 8'h08;
	localparam logic [7:0] PRM_START_EXT = 8'h0A;

	// Physical buffer ids after reset: aux zero, parameter two, config three
	localparam logic [1:0] BUF_AUX_RST = 2'h0;
	localparam logic [1:0] BUF_PRM_RST = 2'h2;
	localparam logic [1:0] BUF_CFG_RST = 2'h3;

	// Field positions
	localparam int CTRL_EXT_BIT = 0;
	localparam int ST_FLAG_BIT = 3;
	localparam int ST_PRM_IRQ_BIT = 4;
	localparam int ST_CFG_IRQ_BIT = 5;
	localparam int ST_START_LSB = 8;

	typedef enum logic [2:0] {
		SPH_WAIT_PRM = 3'b001,
		SPH_WAIT_CFG = 3'b010,
		SPH_DATA_EXCHANGE_STATE = 3'b100
	} sph_state_t;

	// Events from the fieldbus engine, one-cycle pulses except levels
	typedef struct packed {
		logic prm_valid;      // Validated parameter telegram, > 7 bytes
		logic [7:0] prm_len;
		logic cfg_valid;      // Error-free check-configuration telegram
		logic [7:0] cfg_len;
		logic diag_fetched;   // Master fetched the diagnosis
		logic diag_sending;   // Level: device diag buffer is on the wire
		logic stat_diag;      // Level: static bit of device diag buffer
	} sph_fb_evt_t;

	// Controls toward the fieldbus engine and host interrupt logic
	typedef struct packed {
		logic hi_prio;        // Answer next data exchange high priority
		sph_state_t state;
		logic [1:0] aux_buf;
		logic [1:0] prm_buf;
		logic [1:0] cfg_buf;
		logic diag_dev_buf;   // 0 = buffer one, 1 = buffer two
		logic [7:0] prm_start;
		logic new_prm_irq;    // Level
		logic new_cfg_irq;    // Level
		logic diag_chg_irq;   // Pulse
		logic exch_irq;       // Pulse
		logic prm_rej_diag;   // Pulse
		logic cfg_rej_diag;   // Pulse
	} sph_fb_ctl_t;

endpackage : sph_pkg

// File: sim/sph_fb_model.sv
// Fieldbus engine model: turns bench requests into event pulses.
// Assumes requests last one cycle and lengths above seven bytes.
module sph_fb_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go_prm,
	input wire logic go_cfg,
	input wire logic go_fetch,
	input wire logic [7:0] len,
	input wire logic stat,
	input wire logic sending,
	output sph_pkg::sph_fb_evt_t fb_evt
);
	// validated telegrams and fetches as pulses
	// Lengths toggle outside pulses so stale values are never trusted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fb_evt <= '0;
		end else begin
			fb_evt.prm_valid <= go_prm;
			fb_evt.cfg_valid <= go_cfg;
			fb_evt.diag_fetched <= go_fetch;
			fb_evt.prm_len <= go_prm ? len : ~fb_evt.prm_len;
			fb_evt.cfg_len <= go_cfg ? len : ~fb_evt.cfg_len;
			fb_evt.stat_diag <= stat;
			fb_evt.diag_sending <= sending;
		end
	end
endmodule : sph_fb_model

// File: sim/sph_handshake_assertions.sv
// Port assertions for the handshake block.
// Assumes one-wait-state APB reads and same-clock fieldbus events.
module sph_handshake_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire sph_pkg::sph_fb_evt_t fb_evt,
	input wire sph_pkg::sph_fb_ctl_t fb_ctl
);
	// A command acts on the first access cycle only
	wire logic take = psel && penable && !pready && !pwrite;
	wire logic [5:0] idx = paddr[7:2];
	wire logic prm_cmd = take && (idx == sph_pkg::IDX_PRM_OK ||
		idx == sph_pkg::IDX_PRM_NOK);
	wire logic cfg_cmd = take && (idx == sph_pkg::IDX_CFG_OK ||
		idx == sph_pkg::IDX_CFG_NOK);
	wire logic code_rd = pready && !pwrite && idx >= sph_pkg::IDX_PRM_OK &&
		idx <= sph_pkg::IDX_CFG_NOK;
	wire logic in_exch = fb_ctl.state == sph_pkg::SPH_DATA_EXCHANGE_STATE;

	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_prm_irq_set;
		fb_evt.prm_valid |=> fb_ctl.new_prm_irq;
	endproperty
	a_prm_irq_set: assert property (p_prm_irq_set)
		else $error("parameter irq not raised");
	property p_prm_irq_clr;
		$fell(fb_ctl.new_prm_irq) |-> $past(prm_cmd) || $past(prm_cmd, 2);
	endproperty
	a_prm_irq_clr: assert property (p_prm_irq_clr)
		else $error("parameter irq cleared without command");
	property p_cfg_irq_clr;
		$fell(fb_ctl.new_cfg_irq) |-> $past(cfg_cmd) || $past(cfg_cmd, 2);
	endproperty
	a_cfg_irq_clr: assert property (p_cfg_irq_clr)
		else $error("config irq cleared without command");
	property p_prm_rej;
		fb_ctl.prm_rej_diag |-> ##[0:1] fb_ctl.state == sph_pkg::SPH_WAIT_PRM;
	endproperty
	a_prm_rej: assert property (p_prm_rej)
		else $error("parameter reject left wrong state");
	property p_cfg_rej;
		fb_ctl.cfg_rej_diag |-> ##[0:1] fb_ctl.state == sph_pkg::SPH_WAIT_PRM;
	endproperty
	a_cfg_rej: assert property (p_cfg_rej)
		else $error("config reject left wrong state");
	property p_exch_irq;
		$changed(in_exch) |-> ##[0:1] fb_ctl.exch_irq;
	endproperty
	a_exch_irq: assert property (p_exch_irq)
		else $error("exchange entry without irq");
	property p_flag_set;
		fb_ctl.diag_chg_irq |-> ##[0:1] fb_ctl.hi_prio;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("swap did not set diagnosis flag");
	property p_flag_keep;
		fb_ctl.hi_prio && !(fb_evt.diag_fetched && !fb_evt.stat_diag)
			|=> fb_ctl.hi_prio;
	endproperty
	a_flag_keep: assert property (p_flag_keep)
		else $error("diagnosis flag dropped early");
	property p_code;
		code_rd |-> prdata[31:2] == 30'h0 && prdata[1:0] != 2'h2;
	endproperty
	a_code: assert property (p_code)
		else $error("bad command answer code");
	property p_one_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("access not answered");
endmodule : sph_handshake_chk

bind sph_handshake sph_handshake_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.fb_evt(fb_evt), .fb_ctl(fb_ctl));

// File: sim/tb_sph_handshake.sv
// Self-checking bench for the handshake block over APB.
// Assumes the fieldbus model and the bound checker are compiled with it.
module tb_sph_handshake;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic go_prm, go_cfg, go_fetch, stat, sending;
	logic [7:0] paddr, len;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] lfsr_ff;
	logic [1:0] aux, prm, cfg;
	int err_total, n_tests;
	int n_prej, n_crej, n_exch, n_dchg;
	sph_pkg::sph_fb_evt_t fb_evt;
	sph_pkg::sph_fb_ctl_t fb_ctl;

	sph_handshake u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fb_evt(fb_evt), .fb_ctl(fb_ctl));
	sph_fb_model u_fb (.pclk(pclk), .presetn(presetn), .go_prm(go_prm),
		.go_cfg(go_cfg), .go_fetch(go_fetch), .len(len), .stat(stat),
		.sending(sending), .fb_evt(fb_evt));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// Pulse outputs last one cycle, so count them at every edge
	always @(posedge pclk) begin
		n_prej <= n_prej + int'(fb_ctl.prm_rej_diag);
		n_crej <= n_crej + int'(fb_ctl.cfg_rej_diag);
		n_exch <= n_exch + int'(fb_ctl.exch_irq);
		n_dchg <= n_dchg + int'(fb_ctl.diag_chg_irq);
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// Status word: state, flag, both irqs, parameter start byte
	function automatic logic [31:0] st(input logic [2:0] s, input logic f,
		input logic p, input logic c, input logic [7:0] b);
		return {16'h0000, b, 2'h0, c, p, f, s};
	endfunction : st

	function automatic logic [31:0] map();
		return {26'h0000000, cfg, prm, aux};
	endfunction : map

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	// Holds the request until pready is seen, then idles one cycle
	task automatic apb(input logic wr, input logic [5:0] idx,
		input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			end_sim();
		end
		// Data taken at the edge that saw pready; a later drop would
		// leave the access standing and fire the command twice
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rc(input logic [5:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h00000000);
		chk(rd, exp);
	endtask : rc

	// Telegram or fetch with a random length, tracking buffer ids
	task automatic fire(input int k);
		len <= lfsr_ff[7:0] | 8'h08;
		lfsr_ff <= lfsr(lfsr_ff);
		go_prm <= (k == 0);
		go_cfg <= (k == 1);
		go_fetch <= (k == 2);
		if (k == 0) {aux, prm} = {prm, aux};
		if (k == 1) {aux, cfg} = {cfg, aux};
		@(posedge pclk);
		go_prm <= 1'b0;
		go_cfg <= 1'b0;
		go_fetch <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : fire

	initial begin
		{presetn, psel, penable, pwrite, stat, sending} = 6'h00;
		{go_prm, go_cfg, go_fetch} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		len = 8'h08;
		lfsr_ff = 16'h3898;
		err_total = 0;
		n_tests = 0;
		aux = sph_pkg::BUF_AUX_RST;
		prm = sph_pkg::BUF_PRM_RST;
		cfg = sph_pkg::BUF_CFG_RST;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// reset state, ids and diagnosis ownership
		rc(sph_pkg::IDX_STATUS, st(3'h1, 0, 0, 0, 8'h08));
		rc(sph_pkg::IDX_BUF_MAP, map());
		rc(sph_pkg::IDX_DIAG_SM, 32'h00000006);
		// every acknowledge command refused with nothing pending
		for (int i = 0; i < 4; i++) begin
			rc(6'(sph_pkg::IDX_PRM_OK + i), 32'h00000003);
		end
		apb(1'b0, 6'h3F, 32'h00000000);
		chk(rd, 32'h00000000);
		chk({31'h00000000, err}, 32'h00000001);
		// extension bytes move the start byte
		apb(1'b1, sph_pkg::IDX_CTRL, 32'h00000001);
		rc(sph_pkg::IDX_STATUS, st(3'h1, 0, 0, 0, 8'h0A));
		chk({24'h000000, fb_ctl.prm_start}, 32'h0000000A);
		apb(1'b1, sph_pkg::IDX_CTRL, 32'h00000000);
		// swap, ignored write, conflict then finish
		fire(0);
		rc(sph_pkg::IDX_LEN_PRM, {24'h000000, len});
		rc(sph_pkg::IDX_BUF_MAP, map());
		apb(1'b1, sph_pkg::IDX_PRM_OK, 32'h00000000);
		rc(sph_pkg::IDX_STATUS, st(3'h1, 0, 1, 0, 8'h08));
		fire(0);
		rc(sph_pkg::IDX_PRM_OK, 32'h00000001);
		rc(sph_pkg::IDX_BUF_MAP, map());
		rc(sph_pkg::IDX_PRM_OK, 32'h00000000);
		rc(sph_pkg::IDX_STATUS, st(3'h2, 0, 0, 0, 8'h08));
		// parameters acked above, configuration only now
		// read-config copy lies outside, so accept follows at once
		fire(1);
		rc(sph_pkg::IDX_LEN_CFG, {24'h000000, len});
		rc(sph_pkg::IDX_STATUS, st(3'h2, 0, 0, 1, 8'h08));
		rc(sph_pkg::IDX_BUF_MAP, map());
		rc(sph_pkg::IDX_CFG_OK, 32'h00000000);
		rc(sph_pkg::IDX_STATUS, st(3'h4, 0, 0, 0, 8'h08));
		chk({29'h00000000, fb_ctl.state}, 32'h00000004);
		// conflict, then rejects back to waiting
		fire(1);
		fire(1);
		rc(sph_pkg::IDX_CFG_NOK, 32'h00000001);
		rc(sph_pkg::IDX_CFG_NOK, 32'h00000000);
		rc(sph_pkg::IDX_STATUS, st(3'h1, 0, 0, 0, 8'h08));
		fire(0);
		rc(sph_pkg::IDX_PRM_NOK, 32'h00000000);
		rc(sph_pkg::IDX_STATUS, st(3'h1, 0, 0, 0, 8'h08));
		// swap, flag, static and plain fetch
		rc(sph_pkg::IDX_NEW_DIAG, {30'h0, sph_pkg::DG_BUF1});
		rc(sph_pkg::IDX_DIAG_SM, 32'h00000009);
		chk({31'h00000000, fb_ctl.diag_dev_buf}, 32'h00000001);
		rc(sph_pkg::IDX_STATUS, st(3'h1, 1, 0, 0, 8'h08));
		chk({31'h00000000, fb_ctl.hi_prio}, 32'h00000001);
		stat <= 1'b1;
		fire(2);
		rc(sph_pkg::IDX_STATUS, st(3'h1, 1, 0, 0, 8'h08));
		stat <= 1'b0;
		fire(2);
		rc(sph_pkg::IDX_STATUS, st(3'h1, 0, 0, 0, 8'h08));
		sending <= 1'b1;
		rc(sph_pkg::IDX_NEW_DIAG, {30'h0, sph_pkg::DG_NO_BUF});
		sending <= 1'b0;
		repeat (4) @(posedge pclk);
		rc(sph_pkg::IDX_DIAG_SM, 32'h00000006);
		// pulses counted over the whole run
		chk(n_prej, 32'h00000001);
		chk(n_crej, 32'h00000002);
		chk(n_exch, 32'h00000002);
		chk(n_dchg, 32'h00000002);
		end_sim();
	end
endmodule : tb_sph_handshake
